// >>> common/spwm_defs.vh
`ifndef SPWM_DEFS_VH
`define SPWM_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SPWM_CONTROL_OFS     12'h000
`define SPWM_PERIOD_OFS      12'h004
`define SPWM_DUTY_OFS        12'h008
`define SPWM_IRQ_STATUS_OFS  12'h00c
`define SPWM_IRQ_CLEAR_OFS   12'h010
`define SPWM_IRQ_ENABLE_OFS  12'h014

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define SPWM_CTL_ON_BIT      7
`define SPWM_CTL_IE_BIT      6
`define SPWM_CTL_IF_BIT      5
`define SPWM_CTL_GATE_BIT    4
`define SPWM_CTL_POL_BIT     3
`define SPWM_CTL_DIV_HI      2
`define SPWM_CTL_DIV_LO      0

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define SPWM_CONTROL_RST     8'h00
`define SPWM_PERIOD_RST      8'h00
`define SPWM_DUTY_RST        8'h00
`define SPWM_COUNT_START     8'h01
`define SPWM_IRQ_OVF_BIT     0

`endif

// >>> hdl/spwm_core.v
`timescale 1ns/1ps
`include "spwm_defs.vh"

// Period counter with shadowed period and duty
module spwm_core #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // Control
  input  wire         run,
  input  wire         start,
  input  wire         tick,
  input  wire [W-1:0] period_in,
  input  wire [W-1:0] duty_in,
  // State
  output reg  [W-1:0] count,
  output reg          active,
  output reg          ovf_pulse
);

  reg  [W-1:0] period_sh_reg;
  reg  [W-1:0] duty_sh_reg;
  wire [W-1:0] one;
  wire         wrap;
  wire [W-1:0] count_next;

  assign one        = {{(W-1){1'b0}}, 1'b1};
  assign wrap       = (count >= period_sh_reg);
  assign count_next = wrap ? one : count + one;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count         <= {W{1'b0}};
      period_sh_reg <= {W{1'b0}};
      duty_sh_reg   <= {W{1'b0}};
      ovf_pulse     <= 1'b0;
    end else begin
      ovf_pulse <= 1'b0;
      if (start) begin
        count         <= one;
        period_sh_reg <= period_in;
        duty_sh_reg   <= duty_in;
      end else if (run && tick) begin
        count     <= count_next;
        ovf_pulse <= wrap;
        if (wrap) begin
          period_sh_reg <= period_in;
          duty_sh_reg   <= duty_in;
        end
      end
    end
  end

  // ----------------------------------------
  // Active interval
  // ----------------------------------------
  always @* begin
    if (duty_sh_reg == {W{1'b0}})
      active = 1'b0;
    else if (period_sh_reg <= duty_sh_reg)
      active = 1'b1;
    else
      active = (count <= duty_sh_reg);
  end

endmodule // spwm_core

// >>> hdl/spwm_prescaler.v
`timescale 1ns/1ps
`include "spwm_defs.vh"

// Power-of-two divider giving a one-cycle tick per work clock
module spwm_prescaler #(
  parameter SEL_W = 3
) (
  // Clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // Control
  input  wire             run,
  input  wire [SEL_W-1:0] div_sel,
  // Tick out
  output reg              tick
);

  localparam CNT_W = (1 << SEL_W) - 1;

  reg  [CNT_W-1:0] cnt_reg;
  wire [CNT_W-1:0] mask;

  assign mask = ({CNT_W{1'b1}} >> (CNT_W - div_sel)) & {CNT_W{1'b1}};

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  // power-of-two divide
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= {CNT_W{1'b0}};
      tick    <= 1'b0;
    end else if (!run) begin
      cnt_reg <= {CNT_W{1'b0}};
      tick    <= 1'b0;
    end else begin
      // Select change acts at once; mid-count glitch accepted
      if ((cnt_reg & mask) == mask) begin
        cnt_reg <= {CNT_W{1'b0}};
        tick    <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        tick    <= 1'b0;
      end
    end
  end

endmodule // spwm_prescaler

// >>> hdl/spwm_top.v
// Functional notes
// - Clearing module enable stops the counter and turns the output off at once.
// - Setting module enable restarts the counter from value one.
// - The pin is driven only while both module enable and output gate are set.
// - The overflow flag is set only when the counter passes the period and stays until cleared.
// - The overflow interrupt request is raised by the control flag while its enable bit is one, or by the status bit while the enable register is one.
// - With the module on, counting and overflow continue with the output gate off.
// - Output gate changes act immediately.
// - Polarity zero drives high in the active interval, one drives low, acting at once.
// - The active interval lasts the duty count of work clocks in each period.
// - The three-bit divider select divides the clock by two to the power of its code.
// - Writes to the period register set the period; reads return the live counter.
// - Period not above duty gives full active; duty zero gives no active time.
`timescale 1ns/1ps
`include "spwm_defs.vh"

module spwm_top #(
  parameter W = 8
) (
  // APB clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Waveform pin
  output reg         pwm_out,
  output reg         pwm_oe,
  // Interrupt
  output reg         irq
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [7:0]   control_reg;
  reg  [W-1:0] period_value_reg;
  reg  [W-1:0] duty_level_reg;
  reg          irq_status_reg;
  reg          irq_enable_reg;

  wire         module_on;
  wire         overflow_irq_enable;
  wire         output_gate;
  wire         polarity_select;
  wire [2:0]   clock_divider_select;

  assign module_on            = control_reg[`SPWM_CTL_ON_BIT];
  assign overflow_irq_enable  = control_reg[`SPWM_CTL_IE_BIT];
  assign output_gate          = control_reg[`SPWM_CTL_GATE_BIT];
  assign polarity_select      = control_reg[`SPWM_CTL_POL_BIT];
  assign clock_divider_select = control_reg[`SPWM_CTL_DIV_HI:`SPWM_CTL_DIV_LO];

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire access;
  wire wr_en;
  wire rd_en;
  wire hit;

  // One wait state; writes land only on the ready edge, never twice
  assign access = psel && penable;
  assign wr_en  = access && pwrite && pstrb[0] && pready;
  assign rd_en  = access && !pwrite;
  assign hit    = (paddr == `SPWM_CONTROL_OFS)    || (paddr == `SPWM_PERIOD_OFS) ||
                  (paddr == `SPWM_DUTY_OFS)       || (paddr == `SPWM_IRQ_STATUS_OFS) ||
                  (paddr == `SPWM_IRQ_CLEAR_OFS)  || (paddr == `SPWM_IRQ_ENABLE_OFS);

  wire wr_ctl;
  wire wr_clr;

  assign wr_ctl = wr_en && (paddr == `SPWM_CONTROL_OFS);
  assign wr_clr = wr_en && (paddr == `SPWM_IRQ_CLEAR_OFS) && pwdata[`SPWM_IRQ_OVF_BIT];

  // ----------------------------------------
  // Enable edge
  // ----------------------------------------
  wire on_next;
  wire start;

  assign on_next = wr_ctl ? pwdata[`SPWM_CTL_ON_BIT] : module_on;
  assign start   = on_next && !module_on;

  // ----------------------------------------
  // Prescaler and counter
  // ----------------------------------------
  wire         tick;
  wire [W-1:0] count;
  wire         active;
  wire         ovf_pulse;

  spwm_prescaler #(
    .SEL_W   (3)
  ) u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (module_on),
    .div_sel (clock_divider_select),
    .tick    (tick)
  );

  spwm_core #(
    .W         (W)
  ) u_core (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (on_next),
    .start     (start),
    .tick      (tick),
    .period_in (period_value_reg),
    .duty_in   (duty_level_reg),
    .count     (count),
    .active    (active),
    .ovf_pulse (ovf_pulse)
  );

  // ----------------------------------------
  // Control and data registers
  // ----------------------------------------
  reg flag_next;

  always @* begin
    flag_next = control_reg[`SPWM_CTL_IF_BIT];
    if (wr_ctl && !pwdata[`SPWM_CTL_IF_BIT])
      flag_next = 1'b0;
    if (ovf_pulse)
      flag_next = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg      <= `SPWM_CONTROL_RST;
      period_value_reg <= `SPWM_PERIOD_RST;
      duty_level_reg   <= `SPWM_DUTY_RST;
      irq_enable_reg   <= 1'b0;
    end else begin
      if (wr_ctl) begin
        control_reg[7:6] <= pwdata[7:6];
        control_reg[4:0] <= pwdata[4:0];
      end
      control_reg[`SPWM_CTL_IF_BIT] <= flag_next;
      if (wr_en && (paddr == `SPWM_PERIOD_OFS))
        period_value_reg <= pwdata[W-1:0];
      if (wr_en && (paddr == `SPWM_DUTY_OFS))
        duty_level_reg <= pwdata[W-1:0];
      if (wr_en && (paddr == `SPWM_IRQ_ENABLE_OFS))
        irq_enable_reg <= pwdata[`SPWM_IRQ_OVF_BIT];
    end
  end

  // ----------------------------------------
  // Sticky status, write-one clear
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_status_reg <= 1'b0;
    else if (ovf_pulse)
      irq_status_reg <= 1'b1;
    else if (wr_clr)
      irq_status_reg <= 1'b0;
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  reg [31:0] rdata_next;

  always @* begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      `SPWM_CONTROL_OFS:    rdata_next[7:0]   = control_reg;
      `SPWM_PERIOD_OFS:     rdata_next[W-1:0] = count;
      `SPWM_DUTY_OFS:       rdata_next[W-1:0] = duty_level_reg;
      `SPWM_IRQ_STATUS_OFS: rdata_next[0]     = irq_status_reg;
      `SPWM_IRQ_ENABLE_OFS: rdata_next[0]     = irq_enable_reg;
      default:              rdata_next        = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Registered answer: ready one cycle into access phase
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      if (rd_en && !pready)
        prdata <= rdata_next;
    end
  end

  // ----------------------------------------
  // Waveform and interrupt outputs
  // ----------------------------------------
  wire ctl_on_now;
  wire gate_now;
  wire pol_now;
  wire out_act;

  // Look ahead at the write so outputs still react in one cycle
  assign ctl_on_now = on_next;
  assign gate_now   = wr_ctl ? pwdata[`SPWM_CTL_GATE_BIT] : output_gate;
  assign pol_now    = wr_ctl ? pwdata[`SPWM_CTL_POL_BIT]  : polarity_select;
  assign out_act    = active && module_on && !start;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out <= 1'b0;
      pwm_oe  <= 1'b0;
      irq     <= 1'b0;
    end else begin
      pwm_oe  <= ctl_on_now && gate_now;
      pwm_out <= (ctl_on_now && gate_now) ? (out_act ^ pol_now) : 1'b0;
      irq     <= (flag_next && (wr_ctl ? pwdata[`SPWM_CTL_IE_BIT] : overflow_irq_enable)) ||
                 ((ovf_pulse || (irq_status_reg && !wr_clr)) &&
                  (wr_en && (paddr == `SPWM_IRQ_ENABLE_OFS) ?
                   pwdata[`SPWM_IRQ_OVF_BIT] : irq_enable_reg));
    end
  end

endmodule // spwm_top

// >>> verif/spwm_properties.sv
`timescale 1ns/1ps
module spwm_properties #(
  parameter W = 8
) (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Pin and interrupt
  input wire        pwm_out,
  input wire        pwm_oe,
  input wire        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire unmapped;

  assign unmapped = !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014});

  sequence setup_acc;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence ctl_wr;
    psel && penable && pready && pwrite && paddr == 12'h000 && pstrb[0];
  endsequence

  ready_wait_a: assert property (setup_acc |=> pready)
    else $error("pready not one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  err_unmapped_a: assert property (psel && penable && !pready && unmapped |=> pslverr)
    else $error("unmapped access not refused");
  err_only_a: assert property (pslverr |-> pready && unmapped)
    else $error("pslverr without cause");
  read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  off_quiet_a: assert property (!pwm_oe |-> !pwm_out)
    else $error("pin level while not driven");
  stop_now_a: assert property (ctl_wr ##0 !pwdata[7] |-> ##[1:2] !pwm_oe)
    else $error("output not off after disable");
  gate_on_a: assert property (ctl_wr ##0 (pwdata[7] && pwdata[4]) |-> ##[1:2] pwm_oe)
    else $error("output gate slow to open");
  gate_off_a: assert property (ctl_wr ##0 !pwdata[4] |-> ##[1:2] !pwm_oe)
    else $error("output gate slow to close");
endmodule // spwm_properties

bind spwm_top spwm_properties #(.W(W)) spwm_properties_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq)
);

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [3:0]  strb = 4'hf;
  logic [31:0] rdat;
  logic        rerr;
  logic [31:0] keep;
  wire  [31:0] prdata;
  wire         pready, pslverr, pwm_out, pwm_oe, irq;
  int          n_errors = 0;
  int          n_checks = 0;
  int          dv[4] = '{0, 3, 5, 1};
  int          he[4] = '{0, 12, 12, 4};

  spwm_top #(.W(8)) spwm_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq)
  );

  always #20 pclk = ~pclk;

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task close_out;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    // Bounded wait; a stuck slave ends the run
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, pready, 1'b1);
      close_out();
    end else begin
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  // Whole periods in the window keep counts phase-free
  task meas(input int n, input int hi_e, input int ri_e);
    int hi, ri;
    logic prev;
    hi = 0;
    ri = 0;
    @(posedge pclk);
    prev = pwm_out;
    repeat (n) begin
      @(posedge pclk);
      hi += (pwm_out === 1'b1);
      ri += (pwm_out === 1'b1 && prev === 1'b0);
      prev = pwm_out;
    end
    chk(hi, hi_e);
    if (ri_e >= 0)
      chk(ri, ri_e);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (he[i]) rd(12'h004 * i + (i == 4 ? 12'h004 : 12'h000), 32'h0);
    rd(12'h014, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk(rerr, 1'b1);
    $display("test reset done");
    wr(12'h004, 32'h03);
    wr(12'h008, 32'h01);
    for (int d = 0; d < 8; d++) begin
      // Gate closed while the divider moves
      wr(12'h000, 32'h80 | d);
      wr(12'h000, 32'h90 | d);
      repeat (8 << d) @(posedge pclk);
      meas(12 << d, 4 << d, 4);
    end
    chk(pwm_oe, 1'b1);
    wr(12'h000, 32'h87);
    wr(12'h000, 32'h80);
    wr(12'h000, 32'h90);
    for (int i = 0; i < 4; i++) begin
      wr(12'h008, dv[i]);
      repeat (8) @(posedge pclk);
      meas(12, he[i], -1);
    end
    wr(12'h000, 32'h98);
    repeat (4) @(posedge pclk);
    meas(12, 8, 4);
    $display("test waveform done");
    wr(12'h000, 32'h80);
    wr(12'h010, 32'h1);
    repeat (4) @(posedge pclk);
    chk(pwm_oe, 1'b0);
    meas(12, 0, 0);
    rd(12'h00c, 32'h1);
    chk(irq, 1'b0);
    wr(12'h014, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    wr(12'h014, 32'h0);
    wr(12'h000, 32'hc0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    wr(12'h000, 32'h40);
    // Second clear: a flag may be set on the stopping edge
    wr(12'h000, 32'h40);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    keep = rdat;
    rd(12'h004, keep);
    rd(12'h000, 32'h40);
    wr(12'h00c, 32'h0);
    rd(12'h00c, 32'h1);
    wr(12'h010, 32'h1);
    rd(12'h00c, 32'h0);
    strb = 4'he;
    wr(12'h000, 32'h00);
    strb = 4'hf;
    rd(12'h000, 32'h40);
    wr(12'h000, 32'h10);
    repeat (2) @(posedge pclk);
    chk(pwm_oe, 1'b0);
    $display("test timer and irq done");
    wr(12'h004, 32'h10);
    wr(12'h000, 32'h87);
    rd(12'h004, 32'h1);
    $display("test restart done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    $display("test mid-run reset done");
    close_out();
  end
endmodule // tb_top
